/* File: include/radio_id_pkg.sv */
// package: register map and constants for the address and identifier register bank
package radio_id_pkg;
  // register indices as printed; byte address is four times the index
  localparam logic [7:0] IDX_NV_OWN1 = 8'h15;
  localparam logic [7:0] IDX_NV_OWN0 = 8'h16;
  localparam logic [7:0] IDX_NV_MASK3 = 8'h17;
  localparam logic [7:0] IDX_NV_MASK2 = 8'h18;
  localparam logic [7:0] IDX_NV_MASK1 = 8'h19;
  localparam logic [7:0] IDX_NV_MASK0 = 8'h1A;
  localparam logic [7:0] IDX_NV_TGT3 = 8'h1D;
  localparam logic [7:0] IDX_NV_TGT2 = 8'h1E;
  localparam logic [7:0] IDX_OWN1 = 8'h60;
  localparam logic [7:0] IDX_OWN0 = 8'h61;
  localparam logic [7:0] IDX_MASK3 = 8'h62;
  localparam logic [7:0] IDX_MASK2 = 8'h63;
  localparam logic [7:0] IDX_MASK1 = 8'h64;
  localparam logic [7:0] IDX_MASK0 = 8'h65;
  localparam logic [7:0] IDX_TGT3 = 8'h68;
  localparam logic [7:0] IDX_TGT2 = 8'h69;
  // no printed offset for these: chosen indices
  localparam logic [7:0] IDX_NV_OWN2 = 8'h14;
  localparam logic [7:0] IDX_OWN2 = 8'h5F;
  localparam logic [7:0] IDX_CTRL = 8'h80;
  localparam logic [7:0] IDX_STATUS = 8'h81;
  // control register fields
  localparam int CTRL_EXT_BIT = 0;
  localparam int CTRL_MAC_BIT = 1;
  localparam int CTRL_RELOAD_BIT = 2;
  // status register fields
  localparam int STAT_LOADED_BIT = 0;
  localparam int STAT_MATCH_BIT = 1;
  // reset values
  localparam logic [7:0] BYTE_RESET = 8'hFF;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // number of byte slots and their order inside the arrays
  localparam int SLOT_COUNT = 9;
  localparam int SLOT_OWN2 = 0;
  localparam int SLOT_OWN1 = 1;
  localparam int SLOT_OWN0 = 2;
  localparam int SLOT_MASK3 = 3;
  localparam int SLOT_MASK2 = 4;
  localparam int SLOT_MASK1 = 5;
  localparam int SLOT_MASK0 = 6;
  localparam int SLOT_TGT3 = 7;
  localparam int SLOT_TGT2 = 8;
endpackage : radio_id_pkg

/* File: rtl/radio_address_id_registers.sv */
// module: apb register bank for own address, match mask and target identifier bytes
`timescale 1ns/1ps
module radio_address_id_registers (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [31:0] rx_dest_address,
  output logic [31:0] own_address,
  output logic [31:0] match_mask,
  output logic [15:0] target_identifier_high,
  output logic extended_mode,
  output logic mac_mode,
  output logic address_match
);

  ////////////////////////////////////////////////////////////////////////////////
  typedef enum logic [1:0] {
    LOAD_BUSY = 2'b01,
    LOAD_DONE = 2'b10
  } load_state_t;

  logic [7:0] nv_bytes [radio_id_pkg::SLOT_COUNT];
  logic [7:0] work_bytes [radio_id_pkg::SLOT_COUNT];
  logic [7:0] ctrl;
  load_state_t load_state;
  logic reload_req;
  logic match_q;
  logic access;
  logic wr_en;
  logic [7:0] index;
  logic addr_ok;
  logic [31:0] next_prdata;
  logic [31:0] masked_diff;
  // decoded form of the current index, shared by write, read and error paths
  logic [5:0] dec;

  // map an index to a slot, nv flag and hit flag: {hit, nv, slot[3:0]}
  function automatic logic [5:0] decode(input logic [7:0] idx);
    logic [5:0] r;
    r = 6'h00;
    unique case (idx)
      radio_id_pkg::IDX_NV_OWN2: r = {2'b11, 4'(radio_id_pkg::SLOT_OWN2)};
      radio_id_pkg::IDX_NV_OWN1: r = {2'b11, 4'(radio_id_pkg::SLOT_OWN1)};
      radio_id_pkg::IDX_NV_OWN0: r = {2'b11, 4'(radio_id_pkg::SLOT_OWN0)};
      radio_id_pkg::IDX_NV_MASK3: r = {2'b11, 4'(radio_id_pkg::SLOT_MASK3)};
      radio_id_pkg::IDX_NV_MASK2: r = {2'b11, 4'(radio_id_pkg::SLOT_MASK2)};
      radio_id_pkg::IDX_NV_MASK1: r = {2'b11, 4'(radio_id_pkg::SLOT_MASK1)};
      radio_id_pkg::IDX_NV_MASK0: r = {2'b11, 4'(radio_id_pkg::SLOT_MASK0)};
      radio_id_pkg::IDX_NV_TGT3: r = {2'b11, 4'(radio_id_pkg::SLOT_TGT3)};
      radio_id_pkg::IDX_NV_TGT2: r = {2'b11, 4'(radio_id_pkg::SLOT_TGT2)};
      radio_id_pkg::IDX_OWN2: r = {2'b10, 4'(radio_id_pkg::SLOT_OWN2)};
      radio_id_pkg::IDX_OWN1: r = {2'b10, 4'(radio_id_pkg::SLOT_OWN1)};
      radio_id_pkg::IDX_OWN0: r = {2'b10, 4'(radio_id_pkg::SLOT_OWN0)};
      radio_id_pkg::IDX_MASK3: r = {2'b10, 4'(radio_id_pkg::SLOT_MASK3)};
      radio_id_pkg::IDX_MASK2: r = {2'b10, 4'(radio_id_pkg::SLOT_MASK2)};
      radio_id_pkg::IDX_MASK1: r = {2'b10, 4'(radio_id_pkg::SLOT_MASK1)};
      radio_id_pkg::IDX_MASK0: r = {2'b10, 4'(radio_id_pkg::SLOT_MASK0)};
      radio_id_pkg::IDX_TGT3: r = {2'b10, 4'(radio_id_pkg::SLOT_TGT3)};
      radio_id_pkg::IDX_TGT2: r = {2'b10, 4'(radio_id_pkg::SLOT_TGT2)};
      default: r = 6'h00;
    endcase
    return r;
  endfunction : decode

  ////////////////////////////////////////////////////////////////////////////////
  // apb decode: zero wait states, word aligned, unmapped gives pslverr
  assign index = paddr[9:2];
  assign dec = decode(index);
  assign access = psel & penable;
  assign addr_ok = (paddr[1:0] == 2'b00) && (paddr[31:10] == 22'h000000) &&
                   (dec[5] || index == radio_id_pkg::IDX_CTRL ||
                    index == radio_id_pkg::IDX_STATUS);
  assign wr_en = access & pwrite & addr_ok & pstrb[0];
  assign pready = 1'b1;
  assign pslverr = access & ~addr_ok;

  // nonvolatile copies: only the bus writes them, they reset to all ones
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < radio_id_pkg::SLOT_COUNT; i++) begin
        nv_bytes[i] <= radio_id_pkg::BYTE_RESET;
      end
    end else if (wr_en && dec[5] && dec[4]) begin
      nv_bytes[dec[3:0]] <= pwdata[7:0];
    end
  end

  // working copies: loaded from nv after reset or on reload, else by bus writes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < radio_id_pkg::SLOT_COUNT; i++) begin
        work_bytes[i] <= radio_id_pkg::BYTE_RESET;
      end
    end else if (load_state == LOAD_BUSY) begin
      for (int i = 0; i < radio_id_pkg::SLOT_COUNT; i++) begin
        work_bytes[i] <= nv_bytes[i];
      end
    end else if (wr_en && dec[5] && !dec[4]) begin
      work_bytes[dec[3:0]] <= pwdata[7:0];
    end
  end

  // control register; the reload bit is self clearing and never stored
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl <= radio_id_pkg::CTRL_RESET;
    end else if (wr_en && index == radio_id_pkg::IDX_CTRL) begin
      ctrl <= {5'h00, 1'b0, pwdata[radio_id_pkg::CTRL_MAC_BIT],
               pwdata[radio_id_pkg::CTRL_EXT_BIT]};
    end
  end

  assign reload_req = wr_en && index == radio_id_pkg::IDX_CTRL &&
                      pwdata[radio_id_pkg::CTRL_RELOAD_BIT];

  // startup copy runs for one cycle after reset release, again on reload
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      load_state <= LOAD_BUSY;
    end else begin
      unique case (load_state)
        LOAD_BUSY: load_state <= LOAD_DONE;
        LOAD_DONE: load_state <= reload_req ? LOAD_BUSY : LOAD_DONE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // assembled values; user mode clears the upper half
  assign extended_mode = ctrl[radio_id_pkg::CTRL_EXT_BIT];
  assign mac_mode = ctrl[radio_id_pkg::CTRL_MAC_BIT];
  assign own_address[31:24] = extended_mode ? radio_id_pkg::BYTE_RESET : 8'h00;
  assign own_address[23:16] = extended_mode ? work_bytes[radio_id_pkg::SLOT_OWN2] : 8'h00;
  assign own_address[15:8] = work_bytes[radio_id_pkg::SLOT_OWN1];
  assign own_address[7:0] = work_bytes[radio_id_pkg::SLOT_OWN0];
  assign match_mask[31:24] = extended_mode ? work_bytes[radio_id_pkg::SLOT_MASK3] : 8'h00;
  assign match_mask[23:16] = extended_mode ? work_bytes[radio_id_pkg::SLOT_MASK2] : 8'h00;
  assign match_mask[15:8] = work_bytes[radio_id_pkg::SLOT_MASK1];
  assign match_mask[7:0] = work_bytes[radio_id_pkg::SLOT_MASK0];
  // only meaningful in mac mode; reads zero otherwise so stale bytes never leak
  assign target_identifier_high[15:8] = mac_mode ? work_bytes[radio_id_pkg::SLOT_TGT3] : 8'h00;
  assign target_identifier_high[7:0] = mac_mode ? work_bytes[radio_id_pkg::SLOT_TGT2] : 8'h00;

  // masked compare, registered so the flag is a clean flop output
  // own byte 3 is not in this bank, so in extended mode bits 31..24 compare against all ones
  assign masked_diff = (rx_dest_address ^ own_address) & match_mask;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      match_q <= 1'b0;
    end else begin
      match_q <= (masked_diff == 32'h00000000);
    end
  end
  assign address_match = match_q;

  ////////////////////////////////////////////////////////////////////////////////
  // read mux
  always_comb begin
    next_prdata = 32'h00000000;
    if (dec[5]) begin
      next_prdata[7:0] = dec[4] ? nv_bytes[dec[3:0]] : work_bytes[dec[3:0]];
    end else if (index == radio_id_pkg::IDX_CTRL) begin
      next_prdata[7:0] = ctrl;
    end else if (index == radio_id_pkg::IDX_STATUS) begin
      next_prdata[radio_id_pkg::STAT_LOADED_BIT] = (load_state == LOAD_DONE);
      next_prdata[radio_id_pkg::STAT_MATCH_BIT] = match_q;
    end
  end

  // read data flop loads in the setup cycle so it is valid during access
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite && addr_ok) begin
      prdata <= next_prdata;
    end else if (psel && !penable) begin
      prdata <= 32'h00000000;
    end
  end

endmodule : radio_address_id_registers

/* File: testbench/radio_id_chk.sv */
// checker: port-level properties of the address and identifier register bank
`timescale 1ns/1ps
module radio_id_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic pslverr,
  input wire logic [31:0] rx_dest_address,
  input wire logic [31:0] own_address,
  input wire logic [31:0] match_mask,
  input wire logic [15:0] target_identifier_high,
  input wire logic extended_mode,
  input wire logic mac_mode,
  input wire logic address_match
);
  // accepted writes and masked compare; the first edge after reset reloads, so skip it
  wire logic wr = psel && penable && pwrite && pstrb[0];
  wire logic wr_own2 = wr && paddr == 32'h0000017C;
  wire logic wr_own0 = wr && paddr == 32'h00000184;
  wire logic wr_msk3 = wr && paddr == 32'h00000188;
  wire logic [7:0] wd = pwdata[7:0];
  wire logic hit = ((rx_dest_address ^ own_address) & match_mask) == 32'h0;
  logic up;
  always_ff @(posedge clk or posedge rst) if (rst) up <= 1'b0; else up <= 1'b1;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  chk_reset_ones:
  assert property ($fell(rst) |-> own_address == 32'h0000FFFF && match_mask == 32'h0000FFFF)
    else $error("reset value");
  chk_user_own:
  assert property (!extended_mode |-> own_address[31:16] == 16'h0) else $error("own high");
  chk_user_mask:
  assert property (!extended_mode |-> match_mask[31:16] == 16'h0) else $error("mask high");
  chk_target_off:
  assert property (!mac_mode |-> target_identifier_high == 16'h0) else $error("target off");
  chk_masked_match:
  assert property (up |-> address_match == $past(hit)) else $error("match");
  chk_own_low:
  assert property ($past(up) && $past(wr_own0) |-> own_address[7:0] == $past(wd))
    else $error("own byte0");
  chk_own_mid:
  assert property ($past(up) && $past(wr_own2) && extended_mode |-> own_address[23:16] == $past(wd))
    else $error("own byte2");
  chk_mask_top:
  assert property ($past(up) && $past(wr_msk3) && extended_mode |-> match_mask[31:24] == $past(wd))
    else $error("mask byte3");
  chk_misaligned_err:
  assert property (psel && penable && (paddr[1:0] != 2'h0 || paddr[9:2] == 8'h7F) |-> pslverr)
    else $error("slverr");
endmodule : radio_id_chk

/* File: testbench/apb_host.sv */
// partner: apb host model issuing register transfers
`timescale 1ns/1ps
module apb_host (
  input wire logic clk,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [31:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb
);
  // idle bus at time zero; only the low lane carries data
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    pstrb = 4'h1;
  end
  // setup, then access held until pready is seen high, then release
  task automatic xfer(input bit w, input logic [7:0] i, input logic [7:0] d,
                      output logic [31:0] r, output logic e);
    @(posedge clk);
    {psel, penable, pwrite} <= {2'b10, w};
    paddr <= {22'h0, i, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask : xfer
endmodule : apb_host

/* File: testbench/testbench.sv */
// testbench: register map, byte placement, reload and masked compare
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel, penable, pwrite, pready, pslverr, extended_mode, mac_mode, address_match, e;
  logic [31:0] paddr, pwdata, prdata, rx_dest_address, own_address, match_mask, r, x_own, x_msk;
  logic [3:0] pstrb;
  logic [15:0] target_identifier_high;
  logic [7:0] nv[9], w[9];
  logic [7:0] nvi[9] = '{8'h14, 8'h15, 8'h16, 8'h17, 8'h18, 8'h19, 8'h1A, 8'h1D, 8'h1E};
  logic [7:0] wi[9] = '{8'h5F, 8'h60, 8'h61, 8'h62, 8'h63, 8'h64, 8'h65, 8'h68, 8'h69};
  logic xm = 1'b0;
  logic mm = 1'b0;
  int error_cnt = 0;
  int cmp_count = 0;
  always #25 clk = ~clk;
  // model: expected own address and mask from the working bytes
  always_comb begin
    x_own = xm ? {8'hFF, w[0], w[1], w[2]} : {16'h0, w[1], w[2]};
    x_msk = xm ? {w[3], w[4], w[5], w[6]} : {16'h0, w[5], w[6]};
  end
  radio_address_id_registers u_dut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .rx_dest_address, .own_address, .match_mask,
    .target_identifier_high, .extended_mode, .mac_mode, .address_match);
  apb_host u_host (.clk, .pready, .prdata, .pslverr, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb);
  task cmp(input logic [31:0] x, input logic [31:0] g);
    cmp_count++;
    if (g !== x) begin
      error_cnt++;
      $display("BAD t=%0t exp=%h got=%h", $time, x, g);
    end
  endtask : cmp
  task results;
    if (error_cnt == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : results
  // read back both copies of every byte
  task rdall;
    for (int i = 0; i < 9; i++) begin
      u_host.xfer(1'b0, nvi[i], 8'h0, r, e);
      cmp({24'h0, nv[i]}, r);
      u_host.xfer(1'b0, wi[i], 8'h0, r, e);
      cmp({24'h0, w[i]}, r);
    end
  endtask : rdall
  // outputs are combinational, so look between edges
  task outs;
    @(negedge clk);
    cmp(x_own, own_address);
    cmp(x_msk, match_mask);
    cmp(mm ? {16'h0, w[7], w[8]} : 32'h0, {16'h0, target_identifier_high});
    cmp({30'h0, mm, xm}, {30'h0, mac_mode, extended_mode});
  endtask : outs
  ////////////////////////////////////////
  initial begin
    rx_dest_address = 32'h0;
    void'($urandom(75));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    for (int i = 0; i < 9; i++) {nv[i], w[i]} = 16'hFFFF;
    rdall();
    outs();
    // random bytes into both copies, then every mode combination
    for (int i = 0; i < 9; i++) begin
      {nv[i], w[i]} = 16'($urandom);
      u_host.xfer(1'b1, nvi[i], nv[i], r, e);
      u_host.xfer(1'b1, wi[i], w[i], r, e);
    end
    rdall();
    for (int k = 0; k < 4; k++) begin
      {mm, xm} = 2'(k);
      u_host.xfer(1'b1, 8'h80, {6'h0, mm, xm}, r, e);
      outs();
    end
    // half the trials differ only where the mask is zero, so they must match
    for (int k = 0; k < 16; k++) begin
      @(posedge clk);
      rx_dest_address <= x_own ^ ($urandom & (k[0] ? ~x_msk : 32'hFFFFFFFF));
      @(posedge clk);
      @(negedge clk);
      cmp({31'h0, ((rx_dest_address ^ x_own) & x_msk) == 32'h0}, {31'h0, address_match});
    end
    // reload: working bytes take the stored copies, mode bits were cleared by this write
    {mm, xm} = 2'b00;
    w = nv;
    u_host.xfer(1'b1, 8'h80, 8'h04, r, e);
    rdall();
    outs();
    // unmapped index is refused and reads zero
    u_host.xfer(1'b0, 8'h7F, 8'h0, r, e);
    cmp(32'h0, r);
    cmp(32'h1, {31'h0, e});
    results();
  end
  // watchdog: the tests need a few hundred cycles at most
  initial begin
    #2000000;
    error_cnt++;
    results();
  end
endmodule : testbench
bind radio_address_id_registers radio_id_chk u_chk (.clk, .rst, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pstrb, .pslverr, .rx_dest_address, .own_address, .match_mask,
  .target_identifier_high, .extended_mode, .mac_mode, .address_match);
